// >>> design/asmb_top.sv
// Purpose: interrupt status four, masks three and four, supply low limit, pin three
// Assumes: register port is driven by the slave port logic, one access per pulse
// Notes: supply limit and byte count comparisons are made here; all others live elsewhere and feed the event and level inputs
`timescale 1ns/100ps
module asmb_top (
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // event and level sources
  input wire logic completion_code_flag,
  input wire logic thermal_timer_flag,
  input wire logic generic_link_error,
  input wire logic cpu_source0_limit,
  input wire logic cpu_source1_limit,
  input wire logic cpu_source2_limit,
  input wire logic cpu_source3_limit,
  input wire logic link_data_error,
  input wire logic link_link_error_mask_a_error,
  input wire logic overtemp_event,
  input wire logic block_read_done,
  input wire logic [7:0] block_read_count,
  input wire logic module_temps_fetched,
  input wire logic term_supply_valid,
  input wire logic [7:0] term_supply_value,
  input wire logic [7:0] term_supply_high_limit,
  input wire logic out_of_limit_summary,
  // alert, fan override and pin three
  output logic alert_n,
  output logic fan_override,
  input wire logic pin_three_in,
  output logic pin_three_out,
  output logic pin_three_oe_n
);

  // alert from one group: any unmasked source, or the group summary unless masked
  function automatic logic group_alert(input logic [7:0] src, input logic [7:0] msk,
                                       input logic summary_masked);
    group_alert = (|(src & ~msk)) | ((|src) & ~summary_masked);
  endfunction

  // strobe qualified by one register address
  // shared by the clear-on-read decode and every write decode
  function automatic logic reg_hit(input logic strobe, input logic [7:0] addr,
                                   input logic [7:0] want);
    reg_hit = strobe & (addr == want);
  endfunction

  logic [7:0] status_q, status_d;
  logic [7:0] mask3_q, mask3_d;
  logic [7:0] mask4_q, mask4_d;
  logic [7:0] term_low_q, term_low_d;
  logic [7:0] pin_cfg_q, pin_cfg_d;
  logic term_viol_q, term_viol_d;
  logic pin_sample_q, pin_sample_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic alert_q, alert_d;
  logic fan_q, fan_d;
  logic pin_out_q, pin_out_d;
  logic pin_oe_n_q, pin_oe_n_d;
  logic [7:0] set_vec;
  logic [7:0] src3;
  logic short_count;
  logic status_read;

  // event sources for status four
  always_comb begin
    set_vec = 8'h00;
    set_vec[asmb_pkg::ST_COMPLETION] = completion_code_flag;
    set_vec[asmb_pkg::ST_THERMAL_OVERLOAD_OUT_TIMER] = thermal_timer_flag;
    set_vec[asmb_pkg::ST_GENERIC_ERR] = generic_link_error;
    set_vec[asmb_pkg::ST_SRC1] = cpu_source1_limit;
    set_vec[asmb_pkg::ST_SRC2] = cpu_source2_limit;
    set_vec[asmb_pkg::ST_SRC3] = cpu_source3_limit;
    set_vec[asmb_pkg::ST_SHORT_COUNT] = block_read_done & short_count;
    // supply violation set, held by the level
    set_vec[asmb_pkg::ST_TERM_SUPPLY] = term_viol_q;
  end

  // least count depends on what the block read fetched
  assign short_count = module_temps_fetched ?
                       (block_read_count < asmb_pkg::MIN_COUNT_MODULES) :
                       (block_read_count < asmb_pkg::MIN_COUNT_HUB);

  assign status_read = reg_hit(reg_rd, reg_addr, asmb_pkg::ADDR_STATUS_FOUR);

  // mask three group sources, summarised separately from status four
  always_comb begin
    src3 = 8'h00;
    src3[asmb_pkg::M3_SRC0] = cpu_source0_limit;
    src3[asmb_pkg::M3_DATA_ERR] = link_data_error;
    src3[asmb_pkg::M3_LINK_ERROR_MASK_A_ERR] = link_link_error_mask_a_error;
    src3[asmb_pkg::M3_OVERTEMP] = overtemp_event;
  end

  // status four next value
  always_comb begin
    status_d = status_q;
    // sticky until read; a set in the read cycle wins
    if (status_read) begin
      // supply bit clears only once the violation is gone
      status_d = 8'h00;
    end
    // set after clear, so an event in the read cycle is never lost
    status_d = status_d | set_vec;
  end

  // status four register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      status_q <= asmb_pkg::RST_STATUS_FOUR;
    end else begin
      status_q <= status_d;
    end
  end

  // supply violation flag next value
  // refreshed only on a new measurement, so it holds between samples
  always_comb begin
    term_viol_d = term_viol_q;
    if (term_supply_valid) begin
      term_viol_d = (term_supply_value < term_low_q) |
                    (term_supply_value > term_supply_high_limit);
    end
  end

  // supply violation register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      term_viol_q <= 1'b0;
    end else begin
      term_viol_q <= term_viol_d;
    end
  end

  // mask three next value
  // bits 6:0 are stored; bit 4 doubles as the summary mask of status four
  always_comb begin
    mask3_d = mask3_q;
    // mask three write, bit 7 reads zero
    if (reg_hit(reg_wr, reg_addr, asmb_pkg::ADDR_MASK_THREE)) begin
      mask3_d = reg_wdata & asmb_pkg::MASK_THREE_WMASK;
    end
  end

  // mask three register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mask3_q <= asmb_pkg::RST_MASK_THREE;
    end else begin
      mask3_q <= mask3_d;
    end
  end

  // mask four next value; status four itself ignores writes
  always_comb begin
    mask4_d = mask4_q;
    // mask four write, all bits stored
    if (reg_hit(reg_wr, reg_addr, asmb_pkg::ADDR_MASK_FOUR)) begin
      mask4_d = reg_wdata;
    end
  end

  // mask four register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mask4_q <= asmb_pkg::RST_MASK_FOUR;
    end else begin
      mask4_q <= mask4_d;
    end
  end

  // supply low limit next value
  // a new limit only takes effect at the next measurement pulse
  always_comb begin
    term_low_d = term_low_q;
    if (reg_hit(reg_wr, reg_addr, asmb_pkg::ADDR_TERM_LOW)) begin
      term_low_d = reg_wdata;
    end
  end

  // supply low limit register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      term_low_q <= asmb_pkg::RST_TERM_LOW;
    end else begin
      term_low_q <= term_low_d;
    end
  end

  // pin three configuration next value
  always_comb begin
    pin_cfg_d = pin_cfg_q;
    // reserved bits 4:0 are dropped on write
    if (reg_hit(reg_wr, reg_addr, asmb_pkg::ADDR_PIN_THREE)) begin
      pin_cfg_d = reg_wdata & asmb_pkg::PIN_THREE_WMASK;
    end
    // pin level taken one cycle before it can be read back
    pin_sample_d = pin_three_in;
  end

  // pin three configuration and sample registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_cfg_q <= asmb_pkg::RST_PIN_THREE;
      pin_sample_q <= 1'b0;
    end else begin
      pin_cfg_q <= pin_cfg_d;
      pin_sample_q <= pin_sample_d;
    end
  end

  // read data; unmapped addresses answer zero, data holds between reads
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        asmb_pkg::ADDR_STATUS_FOUR: begin
          rdata_d = status_q;
        end
        asmb_pkg::ADDR_MASK_THREE: begin
          rdata_d = mask3_q;
        end
        asmb_pkg::ADDR_MASK_FOUR: begin
          rdata_d = mask4_q;
        end
        asmb_pkg::ADDR_TERM_LOW: begin
          rdata_d = term_low_q;
        end
        asmb_pkg::ADDR_PIN_THREE: begin
          rdata_d = pin_cfg_q;
          // input mode reads the sampled pin
          if (pin_cfg_q[asmb_pkg::PIN_DIR]) begin
            rdata_d[asmb_pkg::PIN_VALUE] = pin_sample_q;
          end
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  // read data registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // alert from both groups
  // group three sources are levels here, so its alert drops with them
  always_comb begin
    // group three needs its masks and the outer summary mask
    // group four needs its masks and summary bit
    alert_d = group_alert(src3, mask3_q, out_of_limit_summary) |
              group_alert(status_q, mask4_q, mask3_q[asmb_pkg::M3_SUMMARY_FOUR]);
  end

  // fan override request
  always_comb begin
    // either error mask disables fan override
    fan_d = (link_data_error | link_link_error_mask_a_error) &
            ~mask3_q[asmb_pkg::M3_DATA_ERR] & ~mask3_q[asmb_pkg::M3_LINK_ERROR_MASK_A_ERR];
  end

  // pin three drive
  // the host must mask the related alert first; nothing here enforces it
  always_comb begin
    // direction one means input, pin released
    pin_oe_n_d = pin_cfg_q[asmb_pkg::PIN_DIR];
    // value through polarity; active low inverts
    pin_out_d = pin_cfg_q[asmb_pkg::PIN_POL] ? pin_cfg_q[asmb_pkg::PIN_VALUE] :
                ~pin_cfg_q[asmb_pkg::PIN_VALUE];
  end

  // output registers; reset leaves alert idle and the pin released
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      alert_q <= 1'b0;
      fan_q <= 1'b0;
      pin_out_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end else begin
      alert_q <= alert_d;
      fan_q <= fan_d;
      pin_out_q <= pin_out_d;
      pin_oe_n_q <= pin_oe_n_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign alert_n = ~alert_q; // open-drain style, low means alert
  assign fan_override = fan_q;
  assign pin_three_out = pin_out_q;
  assign pin_three_oe_n = pin_oe_n_q;

endmodule

// >>> design/asmb_pkg.sv
// Purpose: shared constants for the alert status and mask bank
// Assumes: 8-bit register space reached through the slave register port
// Notes: offsets are the printed register addresses
package asmb_pkg;
  // register addresses
  localparam logic [7:0] ADDR_STATUS_FOUR = 8'h81;
  localparam logic [7:0] ADDR_MASK_THREE = 8'h82;
  localparam logic [7:0] ADDR_MASK_FOUR = 8'h83;
  localparam logic [7:0] ADDR_TERM_LOW = 8'h84;
  localparam logic [7:0] ADDR_PIN_THREE = 8'h85;
  // values after reset
  localparam logic [7:0] RST_STATUS_FOUR = 8'h00;
  localparam logic [7:0] RST_MASK_THREE = 8'h00;
  localparam logic [7:0] RST_MASK_FOUR = 8'h00;
  localparam logic [7:0] RST_TERM_LOW = 8'h00;
  localparam logic [7:0] RST_PIN_THREE = 8'h80;
  // status four bit positions
  localparam int ST_COMPLETION = 0;
  localparam int ST_THERMAL_OVERLOAD_OUT_TIMER = 1;
  localparam int ST_GENERIC_ERR = 2;
  localparam int ST_SRC1 = 3;
  localparam int ST_SRC2 = 4;
  localparam int ST_SRC3 = 5;
  localparam int ST_SHORT_COUNT = 6;
  localparam int ST_TERM_SUPPLY = 7;
  // mask three bit positions
  localparam int M3_SRC0 = 0;
  localparam int M3_DATA_ERR = 1;
  localparam int M3_LINK_ERROR_MASK_A_ERR = 2;
  localparam int M3_OVERTEMP = 3;
  localparam int M3_SUMMARY_FOUR = 4;
  localparam logic [7:0] MASK_THREE_WMASK = 8'h7f;
  // pin three config bit positions
  localparam int PIN_VALUE = 5;
  localparam int PIN_POL = 6;
  localparam int PIN_DIR = 7;
  localparam logic [7:0] PIN_THREE_WMASK = 8'he0;
  // least block-read byte counts
  localparam logic [7:0] MIN_COUNT_HUB = 8'h02;
  localparam logic [7:0] MIN_COUNT_MODULES = 8'h09;
endpackage

// >>> testbench/asmb_host.sv
// Purpose: host side of the register port
// Assumes: one access per call, strobes launched after an edge
// Notes: released lines show the inverse, never the last value
`timescale 1ns/100ps
module asmb_host (
  input wire logic sys_clk,
  input wire logic reg_rvalid,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // one strobe edge; read data holds until the next read
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge sys_clk);
    #1 q = reg_rdata;
  endtask
endmodule

// >>> testbench/asmb_assertions.sv
// Purpose: port checks of the alert bank
// Assumes: bound to the top module
// Notes: masks are unseen here, so only mask-free relations
`timescale 1ns/100ps
module asmb_checker (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rvalid,
  input wire logic [7:0] reg_rdata,
  input wire logic completion_code_flag,
  input wire logic link_data_error,
  input wire logic link_link_error_mask_a_error,
  input wire logic block_read_done,
  input wire logic [7:0] block_read_count,
  input wire logic module_temps_fetched,
  input wire logic fan_override,
  input wire logic pin_three_out,
  input wire logic pin_three_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // decoded strobes and short counts
  wire st_rd = reg_rd && reg_addr == 8'h81;
  wire cfg_wr = reg_wr && reg_addr == 8'h85;
  wire hub = block_read_done && !module_temps_fetched && block_read_count < 8'h02;
  wire mods = block_read_done && module_temps_fetched && block_read_count < 8'h09;
  property p_rvalid; reg_rd |=> reg_rvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("no read answer");
  property p_quiet; !reg_rd |=> !reg_rvalid; endproperty
  a_quiet: assert property (p_quiet) else $error("stray read answer");
  property p_st0; completion_code_flag ##1 st_rd |=> reg_rdata[0]; endproperty
  a_st0: assert property (p_st0) else $error("completion flag lost");
  property p_hub; hub ##1 st_rd |=> reg_rdata[6]; endproperty
  a_hub: assert property (p_hub) else $error("hub short count lost");
  property p_mods; mods ##1 st_rd |=> reg_rdata[6]; endproperty
  a_mods: assert property (p_mods) else $error("module short count lost");
  property p_fan; !link_data_error && !link_link_error_mask_a_error |=> !fan_override; endproperty
  a_fan: assert property (p_fan) else $error("fan override without error");
  property p_dir; cfg_wr |=> ##1 pin_three_oe_n == $past(reg_wdata[7], 2); endproperty
  a_dir: assert property (p_dir) else $error("pin direction wrong");
  property p_pol;
    cfg_wr && !reg_wdata[7] |=> ##1 pin_three_out == ($past(reg_wdata[6], 2) ~^
      $past(reg_wdata[5], 2));
  endproperty
  a_pol: assert property (p_pol) else $error("pin level wrong");
  c_read: cover property (st_rd);
  c_fan: cover property (fan_override);
  c_drive: cover property (!pin_three_oe_n);
endmodule
bind asmb_top asmb_checker u_chk (.sys_clk, .reset, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
  .reg_rvalid, .reg_rdata, .completion_code_flag, .link_data_error, .link_link_error_mask_a_error,
  .block_read_done, .block_read_count, .module_temps_fetched, .fan_override,
  .pin_three_out, .pin_three_oe_n);

// >>> testbench/testbench.sv
// Purpose: self-checking bench of the alert bank
// Assumes: host model drives the register port
// Notes: expected status kept as an integer model
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h", $time, g); end end
module testbench;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, src, cnt, tval, q, hlim;
  logic sys_clk, reset, reg_wr, reg_rd, reg_rvalid, src0, done, fetched, tvalid, summ;
  logic pin_in, alert_n, fan, pout, poe_n, overtemp_alert_mask;
  int n_fail = 0, check_count = 0, st = 0, vio = 0;
  logic [15:0] r = 16'h8548;
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  asmb_host host (.sys_clk, .reg_rvalid, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
  asmb_top dut (.sys_clk, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_rvalid, .completion_code_flag(src[0]), .thermal_timer_flag(src[1]),
    .generic_link_error(src[2]), .cpu_source0_limit(src0), .cpu_source1_limit(src[3]),
    .cpu_source2_limit(src[4]), .cpu_source3_limit(src[5]), .link_data_error(src[6]),
    .link_link_error_mask_a_error(src[7]), .overtemp_event(overtemp_alert_mask), .block_read_done(done),
    .block_read_count(cnt), .module_temps_fetched(fetched), .term_supply_valid(tvalid),
    .term_supply_value(tval), .term_supply_high_limit(hlim), .out_of_limit_summary(summ),
    .alert_n, .fan_override(fan), .pin_three_in(pin_in), .pin_three_out(pout),
    .pin_three_oe_n(poe_n));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.acc(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.acc(1'b0, a, 8'h00, q);
    `CHK(q, e)
  endtask
  // status read; supply bit survives while the violation stands
  task automatic rds();
    rdc(8'h81, st[7:0]);
    st = vio ? 8'h80 : 0;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    results();
  end
  initial begin
    reset = 1'b1;
    {src0, done, fetched, tvalid, summ, pin_in, overtemp_alert_mask} = '0;
    hlim = 8'hf0;
    src = '0;
    cnt = '0;
    tval = '0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    rds();
    rdc(8'h85, 8'h80);
    // random masks; status write must be ignored
    for (int i = 0; i < 3; i++) begin
      r = lfsr(r);
      wr(8'h83, r[7:0]);
      wr(8'h84, r[15:8]);
      wr(8'h82, r[15:8]);
      wr(8'h81, r[7:0]);
      rdc(8'h83, r[7:0]);
      rdc(8'h84, r[15:8]);
      rdc(8'h82, r[15:8] & 8'h7f);
      rds();
    end
    // status sources of bits 0 to 5: open, mask four only, both masks
    for (int b = 0; b < 6; b++) begin
      for (int m = 0; m < 3; m++) begin
        wr(8'h83, m > 0 ? 8'h01 << b : 8'h00);
        wr(8'h82, m > 1 ? 8'h10 : 8'h00);
        @(posedge sys_clk);
        src[b] <= 1'b1;
        st = st | (1 << b);
        repeat (3) @(negedge sys_clk);
        `CHK(alert_n, m > 1)
        rds();
        st = st | (1 << b);
        @(posedge sys_clk);
        src[b] <= 1'b0;
        rds();
        @(negedge sys_clk);
        `CHK(alert_n, 1'b1)
      end
    end
    // byte count table: 1 and 2 hub only, 8 and 9 with modules
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      done <= 1'b1;
      cnt <= 8'(i < 2 ? i + 1 : i + 6);
      fetched <= i > 1;
      if (i % 2 == 0) st = st | 8'h40;
      rds();
      if (i % 2 == 0) st = st | 8'h40;
      @(posedge sys_clk);
      done <= 1'b0;
      rds();
    end
    // supply below low limit, above high limit, then exactly at the low limit
    wr(8'h84, 8'h20);
    for (int v = 0; v < 3; v++) begin
      @(posedge sys_clk);
      tvalid <= 1'b1;
      tval <= v == 0 ? 8'h1f : (v == 1 ? 8'hf1 : 8'h20);
      @(posedge sys_clk);
      tvalid <= 1'b0;
      vio = v < 2;
      if (vio) st = st | 8'h80;
      repeat (3) @(posedge sys_clk);
      rds();
      rds();
    end
    // source zero, then overtemperature, masked: alert follows the summary mask
    for (int s = 0; s < 4; s++) begin
      wr(8'h82, s > 1 ? 8'h08 : 8'h01);
      @(posedge sys_clk);
      src0 <= s < 2;
      overtemp_alert_mask <= s > 1;
      summ <= s % 2;
      repeat (3) @(negedge sys_clk);
      `CHK(alert_n, s % 2)
    end
    wr(8'h82, 8'h00);
    @(negedge sys_clk);
    `CHK(alert_n, 1'b0)
    @(posedge sys_clk);
    src0 <= 1'b0;
    overtemp_alert_mask <= 1'b0;
    summ <= 1'b0;
    // data and link_error_mask_a errors, each mask bit stops the fan override
    for (int k = 6; k < 8; k++) begin
      wr(8'h82, 8'h00);
      @(posedge sys_clk);
      src[k] <= 1'b1;
      repeat (2) @(negedge sys_clk);
      `CHK(fan, 1'b1)
      wr(8'h82, 8'h02 << (k - 6));
      @(negedge sys_clk);
      `CHK(fan, 1'b0)
      @(posedge sys_clk);
      src <= 8'h00;
    end
    wr(8'h83, 8'hff);
    wr(8'h85, 8'h60);
    @(negedge sys_clk);
    `CHK({poe_n, pout}, 2'b01)
    wr(8'h85, 8'h20);
    @(negedge sys_clk);
    `CHK({poe_n, pout}, 2'b00)
    @(posedge sys_clk);
    pin_in <= 1'b1;
    wr(8'h85, 8'h9f);
    rdc(8'h85, 8'ha0);
    `CHK(poe_n, 1'b1)
    results();
  end
endmodule
